// ---- rtl/drbc_map.svh ----
`ifndef DRBC_MAP_SVH
`define DRBC_MAP_SVH

// register byte offsets
`define DRBC_MODE_OFS  4'h0
`define DRBC_STAT_OFS  4'h4

// fields of mode register zero
`define DRBC_BLEN_LSB  0
`define DRBC_RPRE_BIT  2
`define DRBC_WPRE_BIT  3
`define DRBC_CAS_LSB   4
`define DRBC_ADD_LSB   9

// reset value: fixed eight, one-clock preambles, column latency 11
`define DRBC_MODE_RST  32'h0000_00b0

// fields of the status register
`define DRBC_OPEN_LSB  0
`define DRBC_PCH_LSB   8
`define DRBC_BUSY_BIT  16
`define DRBC_WCHOP_BIT 17

// timing
`define DRBC_CLK_NS    100
`define DRBC_TRAS_NS   32
`define DRBC_PCH_NS    14
`define DRBC_TRAS_CYC  (((`DRBC_TRAS_NS + `DRBC_CLK_NS - 1) / `DRBC_CLK_NS) < 1 ? 1 : \
                        ((`DRBC_TRAS_NS + `DRBC_CLK_NS - 1) / `DRBC_CLK_NS))
`define DRBC_PCH_CYC   (((`DRBC_PCH_NS + `DRBC_CLK_NS - 1) / `DRBC_CLK_NS) < 1 ? 1 : \
                        ((`DRBC_PCH_NS + `DRBC_CLK_NS - 1) / `DRBC_CLK_NS))

// depth of the latency pipeline
`define DRBC_DEPTH     64

`endif

// ---- rtl/drbc_pkg.sv ----
package drbc_pkg;

	// command presented on the command clock
	typedef struct packed {
		logic       act;                      // activate bank
		logic       read;                     // read command
		logic       write;                    // write command
		logic       pre;                      // explicit precharge
		logic [2:0] bank;                     // {bank group, bank}
		logic [9:0] col;                      // column address
		logic       auto_precharge_addr_bit;  // precharge after burst
		logic       burst_select_addr_bit;    // per-command length
	} drbc_cmd_t;

	// one read waiting out its latency
	typedef struct packed {
		logic       valid;
		logic       eight;
		logic       ap;
		logic [2:0] bank;
		logic [9:0] col;
	} drbc_entry_t;

	// data and strobe pins, one clock = two beats
	typedef struct packed {
		logic        oe;          // data driven
		logic [15:0] rise;        // beat on rising strobe edge
		logic [15:0] fall;        // beat on falling strobe edge
		logic        strobe_oe;   // strobe driven
		logic        strobe_run;  // strobe toggles, else held low
	} drbc_dq_t;

	// burst length field of mode register zero
	typedef enum logic [1:0] {
		DRBC_BURST_OF_EIGHT  = 2'b00,
		DRBC_PER_COMMAND     = 2'b01,
		DRBC_BURST_CHOP_FOUR = 2'b10,
		DRBC_BURST_RSVD      = 2'b11
	} drbc_blen_t;

endpackage : drbc_pkg

// ---- rtl/drbc_delay_line.sv ----
`timescale 1ns/1ps
`include "drbc_map.svh"
module drbc_delay_line
	import drbc_pkg::*;
(
	input  logic        clk,
	input  logic        reset,
	input  drbc_entry_t push,
	input  logic [5:0]  read_latency,
	output drbc_entry_t taps [6],
	output logic        busy
);
	drbc_entry_t            stage [`DRBC_DEPTH];  // entry i is i+1 clocks old
	logic [`DRBC_DEPTH-1:0] live;                 // valid bit of each stage

	// shift one stage per clock
	genvar i;
	generate
		for (i = 0; i < `DRBC_DEPTH; i++) begin : g_stage
			if (i == 0) begin : g_head
				always_ff @(posedge clk) begin
					if (reset) stage[i] <= '0;
					else stage[i] <= push;
				end
			end else begin : g_body
				always_ff @(posedge clk) begin
					if (reset) stage[i] <= '0;
					else stage[i] <= stage[i-1];
				end
			end
			assign live[i] = stage[i].valid;
		end
	endgenerate

	// taps at ages latency-3 .. latency+2, outputs are registered after this
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			taps[k] = stage[read_latency + 6'(k) - 6'h4];
		end
	end

	assign busy = |live;

endmodule : drbc_delay_line

// ---- rtl/drbc_read_burst.sv ----
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "drbc_map.svh"
module drbc_read_burst
	import drbc_pkg::*;
(
	input  logic        CORE_CLK,
	input  logic        RESET,
	input  logic [3:0]  AVS_ADDRESS,
	input  logic        AVS_READ,
	input  logic        AVS_WRITE,
	input  logic [31:0] AVS_WRITEDATA,
	input  logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic        AVS_WAITREQUEST,
	input  drbc_cmd_t   CMD,
	output drbc_dq_t    DQ
);
	logic [31:0] mode_register_zero;     // burst, preamble and latency setup
	drbc_blen_t  blen;                   // burst length field
	logic        rpre2;                  // two-clock read preamble
	logic [4:0]  column_access_latency;  // column latency in clocks
	logic [1:0]  add_sel;                // additive latency choice
	logic [5:0]  additive_latency;       // additive latency in clocks
	logic [5:0]  read_latency;           // total read latency
	logic        cmd_eight;              // length picked for this command
	logic        last_wr_chop;           // last write was chopped
	logic        bus_ack;                // answer phase of a bus access
	logic        busy;                   // reads in flight
	logic [7:0]  bank_open;              // bank holds an open row
	logic [7:0]  bank_pch;               // bank precharge pending or running
	logic [7:0]  ap_fire;                // burst ended with auto-precharge
	drbc_entry_t push;                   // entry entering the pipeline
	drbc_entry_t taps [6];               // pipeline taps around the latency
	logic        data_hit;               // a burst drives data next clock
	logic        pre_hit;                // a preamble is due next clock
	logic [2:0]  hit_beat;               // beat pair index of the hit
	drbc_entry_t hit;                    // entry that drives data

	// mode register fields
	assign blen                  = drbc_blen_t'(mode_register_zero[`DRBC_BLEN_LSB +: 2]);
	assign rpre2                 = mode_register_zero[`DRBC_RPRE_BIT];
	assign column_access_latency = mode_register_zero[`DRBC_CAS_LSB +: 5];
	assign add_sel               = mode_register_zero[`DRBC_ADD_LSB +: 2];

	// additive latency: zero, latency minus one or minus two
	always_comb begin
		unique case (add_sel)
			2'h1:    additive_latency = {1'b0, column_access_latency} - 6'h1;
			2'h2:    additive_latency = {1'b0, column_access_latency} - 6'h2;
			default: additive_latency = 6'h0;
		endcase
	end
	assign read_latency = additive_latency + {1'b0, column_access_latency};

	// burst length chosen per command
	always_comb begin
		unique case (blen)
			DRBC_PER_COMMAND:     cmd_eight = CMD.burst_select_addr_bit;
			DRBC_BURST_CHOP_FOUR: cmd_eight = 1'b0;
			default:              cmd_eight = 1'b1;
		endcase
	end

	// bus answer one clock after the request, held for that clock only
	always_ff @(posedge CORE_CLK) begin
		if (RESET) bus_ack <= 1'b0;
		else bus_ack <= (AVS_READ | AVS_WRITE) & ~bus_ack;
	end
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~bus_ack;

	// read data captured with the answer, unmapped reads return zero
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			AVS_READDATA <= 32'h0;
		end else if (AVS_READ & ~bus_ack) begin
			unique case (AVS_ADDRESS)
				`DRBC_MODE_OFS: AVS_READDATA <= mode_register_zero;
				`DRBC_STAT_OFS: AVS_READDATA <= {14'h0, last_wr_chop, busy, bank_pch, bank_open};
				default:        AVS_READDATA <= 32'h0;
			endcase
		end
	end

	// mode register write with byte enables, taken when waitrequest is low
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			mode_register_zero <= `DRBC_MODE_RST;
		end else if (AVS_WRITE & bus_ack & (AVS_ADDRESS == `DRBC_MODE_OFS)) begin
			for (int b = 0; b < 4; b++) begin
				if (AVS_BYTEENABLE[b]) mode_register_zero[8*b +: 8] <= AVS_WRITEDATA[8*b +: 8];
			end
		end
	end

	// writes share the length choice; only the length is tracked here
	always_ff @(posedge CORE_CLK) begin
		if (RESET) last_wr_chop <= 1'b0;
		else if (CMD.write) last_wr_chop <= ~cmd_eight;
	end

	// a read enters the latency pipeline with its length and precharge bit
	always_comb begin
		push       = '0;
		push.valid = CMD.read;
		push.eight = cmd_eight;
		push.ap    = CMD.auto_precharge_addr_bit;
		push.bank  = CMD.bank;
		push.col   = CMD.col;
	end

	drbc_delay_line u_delay (
		.clk          (CORE_CLK),
		.reset        (RESET),
		.push         (push),
		.read_latency (read_latency),
		.taps         (taps),
		.busy         (busy)
	);

	// find the burst that owns the next data clock; chop stops after two
	always_comb begin
		data_hit = 1'b0;
		hit_beat = 3'h0;
		hit      = '0;
		ap_fire  = 8'h0;
		for (int k = 0; k < 4; k++) begin
			if (taps[2+k].valid && (k < 2 || taps[2+k].eight)) begin
				data_hit = 1'b1;
				hit_beat = 3'(k);
				hit      = taps[2+k];
				if (taps[2+k].ap && (k == (taps[2+k].eight ? 3 : 1))) begin
					ap_fire[taps[2+k].bank] = 1'b1;
				end
			end
		end
		pre_hit = taps[1].valid | (rpre2 & taps[0].valid);
	end

	// pins: data beats and strobe, preamble holds the strobe low
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			DQ <= '0;
		end else begin
			DQ.oe         <= data_hit;
			DQ.rise       <= {3'h0, hit.bank, hit.col[9:3], {hit_beat[1:0], 1'b0}};
			DQ.fall       <= {3'h0, hit.bank, hit.col[9:3], {hit_beat[1:0], 1'b1}};
			DQ.strobe_oe  <= data_hit | pre_hit;
			DQ.strobe_run <= data_hit;
		end
	end

	// every check of this module runs on the command clock, off during reset
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	// per-bank row state and internal precharge
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_bank
			logic [3:0] ras_cnt;  // row-active time still to run
			logic [3:0] rp_cnt;   // precharge period still to run
			logic       pend;     // auto-precharge waiting for row-active time
			logic       hit_act;  // activate to this bank
			logic       hit_pre;  // explicit precharge to this bank
			assign hit_act = CMD.act & (CMD.bank == 3'(g));
			assign hit_pre = CMD.pre & (CMD.bank == 3'(g));
			assign bank_pch[g] = pend | (rp_cnt != 4'h0);

			// activate opens, auto-precharge closes once the row has been active long enough, explicit precharge closes at once
			always_ff @(posedge CORE_CLK) begin
				if (RESET) begin
					bank_open[g] <= 1'b0;
					ras_cnt      <= 4'h0;
					rp_cnt       <= 4'h0;
					pend         <= 1'b0;
				end else if (hit_act) begin
					bank_open[g] <= 1'b1;
					ras_cnt      <= 4'(`DRBC_TRAS_CYC);
					pend         <= 1'b0;
				end else begin
					if (ras_cnt != 4'h0) ras_cnt <= ras_cnt - 4'h1;
					if (rp_cnt != 4'h0) rp_cnt <= rp_cnt - 4'h1;
					if ((pend | ap_fire[g]) & bank_open[g] & (ras_cnt == 4'h0)) begin
						bank_open[g] <= 1'b0;
						pend         <= 1'b0;
						rp_cnt       <= 4'(`DRBC_PCH_CYC);
					end else if (ap_fire[g] & bank_open[g]) begin
						pend <= 1'b1;
					end else if (hit_pre) begin
						bank_open[g] <= 1'b0;
						pend         <= 1'b0;
						rp_cnt       <= 4'(`DRBC_PCH_CYC);
					end
				end
			end

			property p_ap_close;
				ap_fire[g] && bank_open[g] && ras_cnt == 4'h0 && !hit_act |=> !bank_open[g];
			endproperty
			a_ap_close: assert property (p_ap_close)
				else $error("auto-precharge did not close bank");

			property p_plain_open;
				bank_open[g] && !ap_fire[g] && !pend && !hit_pre |=> bank_open[g];
			endproperty
			a_plain_open: assert property (p_plain_open)
				else $error("bank closed without precharge");
		end
	endgenerate

	// helpers for the checks below
	logic       out_first;  // first data clock of a burst
	logic       out_eight;  // that burst is eight beats
	logic [6:0] since_rd;   // clocks since the last read
	logic [6:0] in_flight;  // reads without first data yet
	drbc_blen_t last_blen;  // length field at the last read
	logic       last_bsel;  // select bit at the last read
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			out_first <= 1'b0;
			out_eight <= 1'b0;
			since_rd  <= 7'h0;
			in_flight <= 7'h0;
			last_blen <= DRBC_BURST_OF_EIGHT;
			last_bsel <= 1'b0;
		end else begin
			out_first <= data_hit & (hit_beat == 3'h0);
			out_eight <= hit.eight;
			since_rd  <= CMD.read ? 7'h1 : (since_rd == 7'h7f ? since_rd : since_rd + 7'h1);
			in_flight <= in_flight + {6'h0, CMD.read} - {6'h0, out_first};
			if (CMD.read) begin
				last_blen <= blen;
				last_bsel <= CMD.burst_select_addr_bit;
			end
		end
	end

	property p_latency;
		out_first && in_flight == 7'h1 && since_rd < 7'h7f |-> since_rd == {1'b0, read_latency};
	endproperty
	a_latency: assert property (p_latency)
		else $error("first data not at read latency");

	property p_eight_len;
		out_first && out_eight |-> DQ.oe [*4] ##1 (!DQ.oe || out_first);
	endproperty
	a_eight_len: assert property (p_eight_len)
		else $error("eight-beat burst not four clocks");

	property p_chop_len;
		out_first && !out_eight |-> DQ.oe ##1 DQ.oe ##1 !DQ.oe;
	endproperty
	a_chop_len: assert property (p_chop_len)
		else $error("chopped burst not two clocks");

	property p_otf;
		out_first && in_flight == 7'h1 && last_blen == DRBC_PER_COMMAND |-> out_eight == last_bsel;
	endproperty
	a_otf: assert property (p_otf)
		else $error("per-command length not honoured");

	property p_fixed8;
		out_first && in_flight == 7'h1 && last_blen == DRBC_BURST_OF_EIGHT |-> out_eight;
	endproperty
	a_fixed8: assert property (p_fixed8)
		else $error("fixed eight gave a chop");

	property p_chop_fixed;
		out_first && in_flight == 7'h1 && last_blen == DRBC_BURST_CHOP_FOUR |-> !out_eight;
	endproperty
	a_chop_fixed: assert property (p_chop_fixed)
		else $error("fixed chop gave eight beats");

	property p_pre1;
		$rose(DQ.strobe_oe) && !rpre2 && in_flight == 7'h1 |-> !DQ.strobe_run ##1 DQ.strobe_run;
	endproperty
	a_pre1: assert property (p_pre1)
		else $error("one-clock preamble wrong");

	property p_pre2;
		$rose(DQ.strobe_oe) && rpre2 && $stable(rpre2) |-> !DQ.strobe_run [*2] ##1 DQ.strobe_run;
	endproperty
	a_pre2: assert property (p_pre2)
		else $error("two-clock preamble wrong");

	property p_gapless;
		out_first && out_eight ##4 out_first |-> $past(DQ.oe) && DQ.strobe_run;
	endproperty
	a_gapless: assert property (p_gapless)
		else $error("gap between back-to-back bursts");

	property p_strobe_data;
		DQ.oe |-> DQ.strobe_oe && DQ.strobe_run;
	endproperty
	a_strobe_data: assert property (p_strobe_data)
		else $error("data without running strobe");

endmodule : drbc_read_burst

// ---- test/drbc_ctrl_model.sv ----
`timescale 1ns/1ps
module drbc_ctrl_model
	import drbc_pkg::*;
(
	input  logic      clk,
	input  logic      reset,
	input  logic      issue,
	input  drbc_cmd_t want,
	input  logic      pre2,
	output drbc_cmd_t cmd
);
	logic [3:0] gap;      // clocks since the last command, saturating
	logic [3:0] min_gap;  // least spacing between two commands

	// four clocks apart at least; five is refused with the 2-clock read preamble
	assign min_gap = 4'h4;

	// one command per request, one clock wide
	always_ff @(posedge clk) begin
		if (reset) begin
			cmd <= '0;
			gap <= 4'hf;
		end else if (issue && gap >= min_gap && !(pre2 && gap == 4'h5)) begin
			// spacing also covers the one-clock precharge wait before an activate
			cmd <= want;
			gap <= 4'h1;
		end else begin
			// idle address lines toggle, top bank bit held low, so a stale value is never trusted
			cmd <= {4'h0, ~cmd[13:0]};
			if (gap != 4'hf)
				gap <= gap + 4'h1;
		end
	end
endmodule : drbc_ctrl_model

// ---- test/drbc_read_burst_tb_top.sv ----
`timescale 1ns/1ps
module drbc_read_burst_tb_top
	import drbc_pkg::*;
();
	logic        core_clk;         // command clock
	logic        reset;            // sync reset
	logic [3:0]  avs_address;      // register bus
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	drbc_cmd_t   cmd;              // from the controller model
	drbc_cmd_t   want;             // command asked of the model
	drbc_dq_t    dq;               // data and strobe pins
	logic        issue;            // request to the model
	logic        pre2;             // 2-clock read preamble in use
	int          fail_count;
	int          compares;
	int          cycles;

	// 10 MHz clock
	initial core_clk = 1'b0;
	always #50 core_clk = ~core_clk;

	drbc_read_burst i_dut (.CORE_CLK(core_clk), .RESET(reset), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_BYTEENABLE(4'hf), .AVS_READDATA(avs_readdata),
		.AVS_WAITREQUEST(avs_waitrequest), .CMD(cmd), .DQ(dq));

	drbc_ctrl_model i_ctrl (.clk(core_clk), .reset(reset), .issue(issue), .want(want),
		.pre2(pre2), .cmd(cmd));

	// compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one register access, held until waitrequest is seen low
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge core_clk);
		avs_read      <= ~wr;
		avs_write     <= wr;
		avs_address   <= a;
		avs_writedata <= d;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge core_clk);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : av

	// mode register image with column latency 11
	function automatic logic [31:0] mr(input logic [1:0] bl, input logic p2, input logic [1:0] add);
		return {21'h0, add, 5'h0b, 1'b0, p2, bl};
	endfunction : mr

	// read command
	function automatic drbc_cmd_t rd(input logic [2:0] b, input logic [9:0] c, input logic ap,
			input logic bs);
		rd = '0;
		rd.read = 1'b1;
		rd.bank = b;
		rd.col = c;
		rd.auto_precharge_addr_bit = ap;
		rd.burst_select_addr_bit = bs;
	endfunction : rd

	// returns at the edge where the device takes the command
	task automatic send(input drbc_cmd_t c, input drbc_cmd_t nxt, input logic more);
		want  <= c;
		issue <= 1'b1;
		@(posedge core_clk);
		while (cmd.read !== 1'b1 && cmd.act !== 1'b1 && cmd.write !== 1'b1)
			@(posedge core_clk);
		want  <= nxt;
		issue <= more;
	endtask : send

	// one or two reads, enables judged each clock, strobe run and data beats only while expected driven; lengths in clocks
	task automatic reads(input drbc_cmd_t a, input drbc_cmd_t b, input logic two, input int lat,
			input int pre, input int la, input int lb);
		int off;
		int d;
		int n;
		logic e_oe;
		logic e_soe;
		logic [15:0] e_r;
		drbc_cmd_t u;
		off = 999;
		send(a, b, two);
		for (int c = 1; c < lat + 16; c++) begin
			@(posedge core_clk);
			if (two && off == 999 && cmd.read === 1'b1) begin
				off = c;
				issue <= 1'b0;
			end
			e_oe = 1'b0;
			e_soe = 1'b0;
			e_r = 16'h0;
			for (int k = 0; k < 2; k++) begin
				u = k ? b : a;
				d = k ? c - off : c;
				n = k ? lb : la;
				if (d >= lat && d < lat + n) begin
					e_oe = 1'b1;
					e_r = {3'h0, u.bank, u.col[9:3], 3'(2 * (d - lat))};
				end
				if (d >= lat - pre && d < lat + n)
					e_soe = 1'b1;
			end
			chk("oe", 32'(e_oe), 32'(dq.oe));
			chk("strobe_oe", 32'(e_soe), 32'(dq.strobe_oe));
			if (e_soe)
				chk("strobe_run", 32'(e_oe), 32'(dq.strobe_run));
			if (e_oe) begin
				chk("rise", 32'(e_r), 32'(dq.rise));
				chk("fall", 32'(e_r + 16'h1), 32'(dq.fall));
			end
		end
	endtask : reads

	// reset values, unmapped place, read-only status
	task automatic t_regs();
		logic [31:0] q;
		av(1'b0, 4'h0, 32'h0, q);
		chk("mode_reset", 32'h0000_00b0, q);
		av(1'b1, 4'h8, 32'hffff_ffff, q);
		av(1'b0, 4'h8, 32'h0, q);
		chk("unmapped", 32'h0, q);
		// the 2-clock write preamble bit is only stored; no write latency field lives here
		av(1'b1, 4'h0, mr(2'h1, 1'b0, 2'h1) | 32'h8, q);
		av(1'b1, 4'h4, 32'hffff_ffff, q);
		av(1'b0, 4'h0, 32'h0, q);
		chk("mode_back", mr(2'h1, 1'b0, 2'h1) | 32'h8, q);
		av(1'b0, 4'h4, 32'h0, q);
		chk("status_ro", 32'h0, q);
	endtask : t_regs

	// every length code with both select values, reads then writes
	task automatic t_modes();
		logic [31:0] q;
		drbc_cmd_t c;
		int len;
		for (int m = 0; m < 8; m++) begin
			av(1'b1, 4'h0, mr(2'(m >> 1), 1'b0, 2'h0), q);
			len = ((m >> 1) == 1) ? (m[0] ? 4 : 2) : (((m >> 1) == 2) ? 2 : 4);
			c = rd(3'(m), 10'h2a8 ^ 10'(m * 8), 1'b0, m[0]);
			reads(c, c, 1'b0, 11, 1, len, len);
			c.read = 1'b0;
			c.write = 1'b1;
			send(c, c, 1'b0);
			repeat (2) @(posedge core_clk);
			av(1'b0, 4'h4, 32'h0, q);
			chk("chop_write", 32'(len == 2), 32'(q[17]));
		end
	endtask : t_modes

	// additive latency codes and preamble lengths
	task automatic t_lat();
		logic [31:0] q;
		for (int a = 0; a < 4; a++) begin
			pre2 <= a[0];
			av(1'b1, 4'h0, mr(2'h0, a[0], 2'(a)), q);
			reads(rd(3'h5, 10'h3f8, 1'b0, 1'b1), '0, 1'b0,
				11 + (a == 1 ? 10 : (a == 2 ? 9 : 0)), a[0] ? 2 : 1, 4, 4);
		end
	endtask : t_lat

	// back-to-back eight-beat reads in different bank groups
	task automatic t_b2b();
		logic [31:0] q;
		for (int p = 0; p < 2; p++) begin
			pre2 <= p[0];
			av(1'b1, 4'h0, mr(2'h0, p[0], 2'h0), q);
			reads(rd(3'h1, 10'h108, 1'b0, 1'b1), rd(3'h6, 10'h210, 1'b0, 1'b1), 1'b1, 11,
				p + 1, 4, 4);
		end
	endtask : t_b2b

	// bank closes after a read with precharge, stays open after a plain read
	task automatic t_ap();
		logic [31:0] q;
		drbc_cmd_t c;
		pre2 <= 1'b0;
		av(1'b1, 4'h0, mr(2'h0, 1'b0, 2'h0), q);
		for (int a = 0; a < 2; a++) begin
			c = '0;
			c.act = 1'b1;
			c.bank = 3'h2;
			send(c, c, 1'b0);
			repeat (2) @(posedge core_clk);
			av(1'b0, 4'h4, 32'h0, q);
			chk("open_after_act", 32'h1, 32'(q[2]));
			reads(rd(3'h2, 10'h040, ~a[0], 1'b1), '0, 1'b0, 11, 1, 4, 4);
			av(1'b0, 4'h4, 32'h0, q);
			chk("open_after_read", 32'(a[0]), 32'(q[2]));
		end
	endtask : t_ap

	// verdict and end of run
	task automatic final_report();
		if (fail_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report

	// hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	// main sequence
	initial begin
		reset = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		want = '0;
		issue = 1'b0;
		pre2 = 1'b0;
		fail_count = 0;
		compares = 0;
		cycles = 0;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		t_regs();
		t_modes();
		t_lat();
		t_b2b();
		t_ap();
		final_report();
	end
endmodule : drbc_read_burst_tb_top
